// ==== rtl/timer_input_cfg.svh ====
// What this block does
// - Switching from clock to timer waits for a four-character confirmation word before it applies.
// - A sensor kind setting selects open collector, low volt range, high volt range, proximity or contact.
// - Three noise rejection levels exist and the applied time depends on level and sensor kind.
// - A contact input level is accepted after 1600us default, 3200us heavy or 400us light.
// - Any other input level is accepted after 40us default, 350us heavy or 5us light.
// - With repeat cycling off the secondary display shows the set time or is off.
// - With repeat cycling on it shows cycle total and number, and counts the delay down to zero.
// - With repeat cycling on, a status label shows briefly, periodically, or the display is off.
// - The cycle total is left off the secondary display when repetition is continuous.
// - Repeat count runs up to 99 periods, or continuous, with a delay between periods.
// - Timing starts and stops from the conditioned input or from the panel buttons.
// - Voltage inputs start on high and stop on low, or the reverse; under panel control the start and stop buttons do so.
// - Contact and open collector inputs start on open and stop on closed, or the reverse.
// - Start commands are ignored while the set time is zero.
`ifndef TIMER_INPUT_CFG_SVH
`define TIMER_INPUT_CFG_SVH

`define CLK_PERIOD_NS        10
`define DB_CONTACT_DEF_US    1600
`define DB_CONTACT_HEAVY_US  3200
`define DB_CONTACT_LIGHT_US  400
`define DB_OTHER_DEF_US      40
`define DB_OTHER_HEAVY_US    350
`define DB_OTHER_LIGHT_US    5
`define US_TO_CYC(us)        (((us) * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MS_TO_CYC(ms)        (((ms) * 64'd1000000) / `CLK_PERIOD_NS)
`define LABEL_HOLD_MS        1000
`define LABEL_PERIOD_MS      5000
`define MAX_REPEAT           7'h63
`define CONFIRM_DIGITS       3'h4
`define CONFIRM_WORD_RST     32'h53757245
`define RESET_IS_TIMER       1'b1

`endif

// ==== rtl/timer_input_pkg.sv ====
package timer_input_pkg;

    typedef enum logic [2:0] {
        OPEN_COLLECTOR_SEL,
        VOLT_RANGE_LOW_SEL,
        VOLT_RANGE_HIGH_SEL,
        PROXIMITY_SEL,
        CONTACT_SEL
    } sensor_kind_t;

    typedef enum logic [1:0] {
        NOISE_DEFAULT,
        NOISE_HEAVY,
        NOISE_LIGHT
    } noise_level_t;

    // mode 0 is set time (repeat off) or brief label (repeat on)
    typedef enum logic [1:0] {
        DISP_PRIMARY,
        DISP_PERIODIC_LABEL,
        DISP_OFF
    } display_mode_t;

    typedef enum logic {
        RUN_OPTION_1,
        RUN_OPTION_2
    } run_option_t;

    typedef struct packed {
        logic show_set_time;
        logic show_cycle_num;
        logic show_cycle_total;
        logic show_delay_count;
        logic show_label;
        logic blank;
    } disp_view_t;

    typedef struct packed {
        logic       repeat_cycle_function;
        logic [6:0] cycle_count;
        logic       in_delay;
        logic       period_start;
    } repeat_status_t;

endpackage : timer_input_pkg

// ==== rtl/noise_filter.sv ====
`timescale 1ns/100ps
`include "timer_input_cfg.svh"
module noise_filter #(
    parameter int CNT_W = 19
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // raw sample and required run length
    input  wire logic             i_sample,
    input  wire logic [CNT_W-1:0] i_need,
    // accepted level
    output logic                  o_level
);
    logic [CNT_W-1:0] run_reg;

    // count cycles the sample differs from the accepted level
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            run_reg <= '0;
            o_level <= 1'b0;
        end
        else if (i_sample == o_level)
        begin
            run_reg <= '0; // early return restarts the count
        end
        else if (run_reg >= i_need - 1'b1)
        begin
            o_level <= i_sample; // held long enough
            run_reg <= '0;
        end
        else
        begin
            run_reg <= run_reg + 1'b1;
        end
    end

    filter_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $changed(o_level) |-> $past(run_reg) >= $past(i_need) - 1'b1
                              && $past(i_sample) == o_level)
        else $error("level accepted before the required run");

    filter_restart_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sample == o_level) |=> run_reg == '0)
        else $error("run count not restarted on level return");

endmodule : noise_filter

// ==== rtl/timer_input_debounce_control.sv ====
`timescale 1ns/100ps
`include "timer_input_cfg.svh"
module timer_input_debounce_control
    import timer_input_pkg::*;
#(
    parameter int unsigned CNT_W         = 19,
    parameter int unsigned DB_C_DEF_CYC  = `US_TO_CYC(`DB_CONTACT_DEF_US),
    parameter int unsigned DB_C_HVY_CYC  = `US_TO_CYC(`DB_CONTACT_HEAVY_US),
    parameter int unsigned DB_C_LGT_CYC  = `US_TO_CYC(`DB_CONTACT_LIGHT_US),
    parameter int unsigned DB_O_HVY_CYC  = `US_TO_CYC(`DB_OTHER_HEAVY_US),
    parameter int unsigned LABEL_HOLD    = 32'(`MS_TO_CYC(`LABEL_HOLD_MS)),
    parameter int unsigned LABEL_PERIOD  = 32'(`MS_TO_CYC(`LABEL_PERIOD_MS)),
    parameter logic [31:0] CONFIRM_WORD  = `CONFIRM_WORD_RST
) (
    // clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    // function change menu
    input  wire logic          i_select_timer,
    input  wire logic          i_select_clock,
    input  wire logic          i_digit_valid,
    input  wire logic [7:0]    i_digit,
    input  wire logic          i_enter,
    output logic               o_timer_function_value,
    output logic               o_menu_return,
    // input conditioning
    input  wire logic          i_sensor_level,
    input  sensor_kind_t       i_sensor_kind_select,
    input  noise_level_t       i_noise_reject_level,
    output logic               o_accepted_level,
    // run control
    input  run_option_t        i_run_control_select,
    input  wire logic          i_panel_control,
    input  wire logic          i_btn_start,
    input  wire logic          i_btn_stop,
    input  wire logic          i_timer_done,
    input  wire logic [19:0]   i_set_time,
    output logic               o_run,
    // secondary display
    input  display_mode_t      i_secondary_display_mode,
    input  repeat_status_t     i_repeat,
    output disp_view_t         o_view,
    output logic [6:0]         o_cycle_total
);
    typedef enum {FN_CLOCK, FN_CONFIRM, FN_WAIT_ENTER, FN_TIMER} fn_state_t;

    fn_state_t        fn_reg;
    logic [31:0]      word_reg;
    logic [2:0]       digits_reg;
    logic [CNT_W-1:0] need;
    logic             contact_like;
    logic             want_run;
    logic             want_reg;
    logic             zero_set;
    logic [31:0]      label_cnt_reg;
    logic             label_on;
    logic [6:0]       total_eff;
    disp_view_t       view_next;

    // function change: timer needs the word typed in before it applies
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            fn_reg        <= `RESET_IS_TIMER ? FN_TIMER : FN_CLOCK;
            word_reg      <= 32'h00000000;
            digits_reg    <= 3'h0;
            o_menu_return <= 1'b0;
        end
        else
        begin
            o_menu_return <= 1'b0;
            case (fn_reg)
                FN_CLOCK:
                    if (i_select_timer)
                    begin
                        fn_reg     <= FN_CONFIRM;
                        word_reg   <= 32'h00000000;
                        digits_reg <= 3'h0;
                    end
                FN_CONFIRM:
                    if (i_digit_valid)
                    begin
                        word_reg   <= {word_reg[23:0], i_digit}; // digit by digit
                        digits_reg <= digits_reg + 3'h1;
                        if (digits_reg == `CONFIRM_DIGITS - 3'h1)
                            fn_reg <= FN_WAIT_ENTER;
                    end
                FN_WAIT_ENTER:
                    if (i_enter)
                    begin
                        // a wrong word leaves the instrument a clock
                        fn_reg        <= (word_reg == CONFIRM_WORD) ? FN_TIMER : FN_CLOCK;
                        o_menu_return <= 1'b1;
                    end
                FN_TIMER:
                    if (i_select_clock)
                        fn_reg <= FN_CLOCK;
                default:
                    fn_reg <= FN_CLOCK;
            endcase
        end
    end

    assign o_timer_function_value = (fn_reg == FN_TIMER);

    fn_confirm_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_timer_function_value) |-> $past(fn_reg) == FN_WAIT_ENTER
                                          && $past(word_reg) == CONFIRM_WORD
                                          && o_menu_return)
        else $error("timer function applied without confirmation");

    // required run length from sensor kind and rejection level
    always_comb
    begin
        need = CNT_W'(`US_TO_CYC(`DB_OTHER_DEF_US));
        if (i_sensor_kind_select == CONTACT_SEL)
        begin
            case (i_noise_reject_level)
                NOISE_HEAVY: need = CNT_W'(DB_C_HVY_CYC);
                NOISE_LIGHT: need = CNT_W'(DB_C_LGT_CYC);
                default:     need = CNT_W'(DB_C_DEF_CYC);
            endcase
        end
        else
        begin
            case (i_noise_reject_level)
                NOISE_HEAVY: need = CNT_W'(DB_O_HVY_CYC);
                NOISE_LIGHT: need = CNT_W'(`US_TO_CYC(`DB_OTHER_LIGHT_US));
                default:     need = CNT_W'(`US_TO_CYC(`DB_OTHER_DEF_US));
            endcase
        end
    end

    contact_time_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sensor_kind_select == CONTACT_SEL && i_noise_reject_level == NOISE_DEFAULT)
        |-> need == CNT_W'(DB_C_DEF_CYC))
        else $error("contact default run length wrong");

    other_time_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_sensor_kind_select != CONTACT_SEL && i_noise_reject_level == NOISE_LIGHT)
        |-> need == CNT_W'(`US_TO_CYC(`DB_OTHER_LIGHT_US)))
        else $error("non contact light run length wrong");

    // comparator output already carries the threshold hysteresis
    noise_filter #(
        .CNT_W (CNT_W)
    ) u_filter (
        .i_clk    (i_clk),
        .i_rst    (i_rst),
        .i_sample (i_sensor_level),
        .i_need   (need),
        .o_level  (o_accepted_level)
    );

    // high accepted level is open contact or low sensor current
    assign contact_like = (i_sensor_kind_select == CONTACT_SEL)
                       || (i_sensor_kind_select == OPEN_COLLECTOR_SEL)
                       || (i_sensor_kind_select == PROXIMITY_SEL);
    // option 1: voltage high starts contact open starts
    assign want_run = o_accepted_level ^ (i_run_control_select == RUN_OPTION_2);
    assign zero_set = (i_set_time == 20'h00000);

    // run state; an input edge is a command, so a held level cannot restart a done timer
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_run    <= 1'b0;
            want_reg <= 1'b0;
        end
        else
        begin
            want_reg <= want_run;
            if (i_timer_done)
                o_run <= 1'b0;
            else if (i_panel_control) // buttons drive the timer
            begin
                if (i_btn_stop)
                    o_run <= 1'b0;
                else if (i_btn_start && !zero_set)
                    o_run <= 1'b1;
            end
            else if (want_run && !want_reg && !zero_set)
                o_run <= 1'b1;
            else if (!want_run && want_reg)
                o_run <= 1'b0;
        end
    end

    zero_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_run) |-> $past(i_set_time) != 20'h00000)
        else $error("timer started with zero set time");

    volt_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_panel_control && !contact_like && i_run_control_select == RUN_OPTION_1
         && $rose(o_accepted_level) && !zero_set && !i_timer_done) |=> o_run)
        else $error("voltage high did not start timing");

    contact_stop_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_panel_control && contact_like && i_run_control_select == RUN_OPTION_1
         && $fell(o_accepted_level)) |=> !o_run)
        else $error("closed contact did not stop timing");

    // label timer restarts on every cycle or delay period
    always_ff @(posedge i_clk)
    begin
        if (i_rst || i_repeat.period_start)
            label_cnt_reg <= 32'h00000000;
        else if (i_secondary_display_mode == DISP_PERIODIC_LABEL
                 && label_cnt_reg >= LABEL_PERIOD - 1)
            label_cnt_reg <= 32'h00000000; // periodic wrap
        else if (label_cnt_reg < LABEL_PERIOD)
            label_cnt_reg <= label_cnt_reg + 32'h00000001; // brief mode saturates
    end

    assign label_on = label_cnt_reg < LABEL_HOLD;
    // counts above the limit are clamped; zero means continuous
    assign total_eff = (i_repeat.cycle_count > `MAX_REPEAT) ? `MAX_REPEAT
                                                             : i_repeat.cycle_count;

    // what the secondary display carries
    always_comb
    begin
        view_next = '0;
        if (i_secondary_display_mode == DISP_OFF)
            view_next.blank = 1'b1;
        else if (!i_repeat.repeat_cycle_function)
            view_next.show_set_time = 1'b1;
        else
        begin
            view_next.show_cycle_num   = !i_repeat.in_delay;
            view_next.show_cycle_total = !i_repeat.in_delay && total_eff != 7'h00;
            view_next.show_delay_count = i_repeat.in_delay;
            view_next.show_label       = label_on;
        end
    end

    // display outputs registered
    always_ff @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_view        <= '0;
            o_cycle_total <= 7'h00;
        end
        else
        begin
            o_view        <= view_next;
            o_cycle_total <= total_eff;
        end
    end

    repeat_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (!i_repeat.repeat_cycle_function && i_secondary_display_mode != DISP_OFF)
        |=> o_view.show_set_time && !o_view.show_cycle_num && !o_view.show_label)
        else $error("repeat off view not set time");

    no_total_a: assert property (@(posedge i_clk) disable iff (i_rst)
        o_view.show_cycle_total |-> o_cycle_total != 7'h00 && o_cycle_total <= `MAX_REPEAT)
        else $error("cycle total shown for continuous repetition");

    delay_view_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_repeat.repeat_cycle_function && i_repeat.in_delay
         && i_secondary_display_mode != DISP_OFF)
        |=> o_view.show_delay_count && !o_view.show_cycle_num)
        else $error("delay countdown not shown");

endmodule : timer_input_debounce_control

// ==== bench/sensor_source.sv ====
`timescale 1ns/100ps
module sensor_source (
    // clock
    input  wire logic i_clk,
    // comparator level toward the block
    output logic      o_level
);
    initial o_level = 1'b0;

    // called at an edge: the level is sampled on the next n edges, so runs chain exactly
    task automatic drive(input logic lvl, input int n);
        o_level <= lvl;
        repeat (n) @(posedge i_clk);
    endtask : drive
endmodule : sensor_source

// ==== bench/timer_input_debounce_control_test.sv ====
`timescale 1ns/100ps
module timer_input_debounce_control_test;
    import timer_input_pkg::*;
    // arbitrary confirmation word, chosen for this bench only
    localparam logic [31:0] CW = 32'h1A2B3C4D;
    // short run lengths keep the bench fast; contact levels keep the 4:8:1 ratio
    localparam int          CDB = 10;
    localparam int          LBL = 5;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    logic           sel_t = 1'b0, sel_c = 1'b0, dv = 1'b0, ent = 1'b0;
    logic [7:0]     dig = 8'h00;
    logic           tmr, ret, sens, acc, run;
    sensor_kind_t   kind = CONTACT_SEL;
    noise_level_t   lvl = NOISE_LIGHT;
    run_option_t    opt = RUN_OPTION_1;
    logic           panel = 1'b0, bst = 1'b0, bsp = 1'b0, done = 1'b0;
    logic [19:0]    set_t = 20'h00005;
    display_mode_t  mode = DISP_PRIMARY;
    repeat_status_t rep = '0;
    disp_view_t     view;
    logic [6:0]     ctot;
    int             err_total = 0;
    int             checks_done = 0;

    always #5 clk = ~clk;

    sensor_source src (.i_clk(clk), .o_level(sens));

    timer_input_debounce_control #(
        .DB_C_DEF_CYC(4 * CDB), .DB_C_HVY_CYC(8 * CDB), .DB_C_LGT_CYC(CDB),
        .DB_O_HVY_CYC(CDB - 1), .LABEL_HOLD(LBL), .LABEL_PERIOD(4 * LBL), .CONFIRM_WORD(CW)
    ) dut (
        .i_clk(clk), .i_rst(rst), .i_select_timer(sel_t), .i_select_clock(sel_c),
        .i_digit_valid(dv), .i_digit(dig), .i_enter(ent), .o_timer_function_value(tmr),
        .o_menu_return(ret), .i_sensor_level(sens), .i_sensor_kind_select(kind),
        .i_noise_reject_level(lvl), .o_accepted_level(acc), .i_run_control_select(opt),
        .i_panel_control(panel), .i_btn_start(bst), .i_btn_stop(bsp), .i_timer_done(done),
        .i_set_time(set_t), .o_run(run), .i_secondary_display_mode(mode), .i_repeat(rep),
        .o_view(view), .o_cycle_total(ctot)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic give_verdict;
        if (err_total == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict

    // the accepted level is looked at once the edge's updates have landed
    task automatic acc_at(input logic e);
        fork
            begin
                #1;
                check(acc, e);
            end
        join_none
    endtask : acc_at

    // a rise and a fall through the filter, with an early return on the rise that must restart the count
    task automatic filt(input sensor_kind_t k, input noise_level_t l, input int n);
        @(posedge clk);
        kind <= k;
        lvl  <= l;
        src.drive(1'b0, 2);
        src.drive(1'b1, n - 1);
        acc_at(1'b0);
        src.drive(1'b0, 1);
        src.drive(1'b1, n - 1);
        acc_at(1'b0);
        src.drive(1'b1, 1);
        acc_at(1'b1);
        src.drive(1'b0, n - 1);
        acc_at(1'b1);
        src.drive(1'b0, 1);
        acc_at(1'b0);
        #2;
    endtask : filt

    // settle a level long enough to pass the filter, then one more edge for the run flag
    task automatic sense(input logic l, input int n);
        @(posedge clk);
        src.drive(l, n + 1);
        #1;
    endtask : sense

    task automatic menu(input logic [31:0] w, input logic exp);
        @(posedge clk);
        sel_t <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            sel_t <= 1'b0;
            dv    <= 1'b1;
            dig   <= w[31 - 8 * i -: 8];
        end
        @(posedge clk);
        dv  <= 1'b0;
        ent <= 1'b1;
        @(posedge clk);
        ent <= 1'b0;
        #1;
        check(ret, 1'b1);
        check(tmr, exp);
        @(posedge clk);
        #1;
        check(ret, 1'b0);
    endtask : menu

    task automatic menu_test;
        @(posedge clk);
        sel_c <= 1'b1;
        @(posedge clk);
        sel_c <= 1'b0;
        @(posedge clk);
        #1;
        check(tmr, 1'b0);
        menu(CW ^ 32'h00000001, 1'b0);
        menu(CW, 1'b1);
    endtask : menu_test

    task automatic pulse_btn(input logic s, input logic p, input logic exp);
        @(posedge clk);
        bst <= s;
        bsp <= p;
        @(posedge clk);
        bst <= 1'b0;
        bsp <= 1'b0;
        @(posedge clk);
        #1;
        check(run, exp);
    endtask : pulse_btn

    task automatic run_test;
        @(posedge clk);
        kind <= CONTACT_SEL;
        lvl  <= NOISE_LIGHT;
        sense(1'b1, 10);
        check(run, 1'b1);
        sense(1'b0, 10);
        check(run, 1'b0);
        set_t <= 20'h00000;
        sense(1'b1, 10);
        check(run, 1'b0);
        set_t <= 20'h00005;
        repeat (3) @(posedge clk);
        #1;
        check(run, 1'b0);
        opt <= RUN_OPTION_2;
        sense(1'b0, 10);
        check(run, 1'b1);
        sense(1'b1, 10);
        check(run, 1'b0);
        set_t <= 20'h00000;
        opt   <= RUN_OPTION_1;
        kind  <= VOLT_RANGE_HIGH_SEL;
        sense(1'b0, 500);
        set_t <= 20'h00005;
        sense(1'b1, 500);
        check(run, 1'b1);
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        @(posedge clk);
        #1;
        check(run, 1'b0);
        panel <= 1'b1;
        pulse_btn(1'b1, 1'b0, 1'b1);
        sense(1'b0, 500);
        check(run, 1'b1);
        pulse_btn(1'b1, 1'b1, 1'b0);
        set_t <= 20'h00000;
        pulse_btn(1'b1, 1'b0, 1'b0);
    endtask : run_test

    task automatic disp(input display_mode_t m, input repeat_status_t r);
        @(posedge clk);
        mode <= m;
        rep  <= r;
        repeat (3) @(posedge clk);
        #1;
    endtask : disp

    task automatic label(input display_mode_t m, input logic late);
        disp(m, '{1'b1, 7'h05, 1'b0, 1'b1});
        rep.period_start <= 1'b0;
        check(view.show_label, 1'b1);
        repeat (9) @(posedge clk);
        #1;
        check(view.show_label, 1'b0);
        // the periodic label returns once the count wraps past one full period
        repeat (13) @(posedge clk);
        #1;
        check(view.show_label, late);
    endtask : label

    task automatic disp_test;
        disp(DISP_PRIMARY, '{1'b0, 7'h05, 1'b0, 1'b0});
        check(view.show_set_time, 1'b1);
        disp(DISP_OFF, '{1'b0, 7'h05, 1'b0, 1'b0});
        check(view.blank, 1'b1);
        check(view.show_set_time, 1'b0);
        disp(DISP_PRIMARY, '{1'b1, 7'h05, 1'b0, 1'b0});
        check(view.show_cycle_num, 1'b1);
        check(view.show_cycle_total, 1'b1);
        check(ctot, 7'h05);
        disp(DISP_PRIMARY, '{1'b1, 7'h78, 1'b0, 1'b0});
        check(ctot, 7'h63);
        disp(DISP_PRIMARY, '{1'b1, 7'h00, 1'b0, 1'b0});
        check(view.show_cycle_total, 1'b0);
        disp(DISP_PRIMARY, '{1'b1, 7'h05, 1'b1, 1'b0});
        check(view.show_delay_count, 1'b1);
        check(view.show_cycle_num, 1'b0);
        disp(DISP_OFF, '{1'b1, 7'h05, 1'b0, 1'b0});
        check(view.blank, 1'b1);
        label(DISP_PRIMARY, 1'b0);
        label(DISP_PERIODIC_LABEL, 1'b1);
    endtask : disp_test

    // watchdog sized well above the longest filter runs, about 20k cycles in all
    initial
    begin
        #500000;
        err_total++;
        give_verdict();
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        // reset values are looked at before the first free edge updates the view
        #1;
        check(tmr, 1'b1);
        check({acc, run, view, ctot}, 15'h0000);
        menu_test();
        filt(CONTACT_SEL, NOISE_DEFAULT, 4 * CDB);
        filt(CONTACT_SEL, NOISE_HEAVY, 8 * CDB);
        filt(CONTACT_SEL, NOISE_LIGHT, CDB);
        filt(VOLT_RANGE_LOW_SEL, NOISE_DEFAULT, 4000);
        filt(VOLT_RANGE_LOW_SEL, NOISE_HEAVY, CDB - 1);
        filt(VOLT_RANGE_LOW_SEL, NOISE_LIGHT, 500);
        filt(OPEN_COLLECTOR_SEL, NOISE_LIGHT, 500);
        filt(VOLT_RANGE_HIGH_SEL, NOISE_LIGHT, 500);
        filt(PROXIMITY_SEL, NOISE_LIGHT, 500);
        run_test();
        disp_test();
        give_verdict();
    end
endmodule : timer_input_debounce_control_test
